/* File: fes_defs.svh */
// Constants of the front-end section command and data link logic
`ifndef FES_DEFS_SVH
`define FES_DEFS_SVH
`define FES_CODE_W        5
`define FES_WDATA_W       16
`define FES_STAMP_W       5
`define FES_DEPTH         4
`define FES_PTR_W         2
`define FES_CNT_W         3
`define FES_BITCNT_W      5
`define FES_FRAME_W       64
`define FES_LEN_W         7
`define FES_RT_NOOP       5'h00
`define FES_RT_L1A        5'h01
`define FES_RT_READ       5'h02
`define FES_RT_SYNC       5'h03
`define FES_RT_CLEAR      5'h04
`define FES_SU_READBACK   5'h1B
`define FES_SU_WRITE      5'h1D
`define FES_SU_RESET      5'h1E
`define FES_SU_RSVD       5'h1F
`define FES_FIELD_LAST    5'h04
`define FES_WDATA_LAST    5'h0F
`define FES_EVT_LEN       7'h40
`define FES_RB_LEN        7'h30
`define FES_RATE_FULL     2'h0
`define FES_RATE_HALF     2'h1
`define FES_DIV_FULL      2'h0
`define FES_DIV_HALF      2'h1
`define FES_DIV_QUARTER   2'h3
`define FES_CLK_PERIOD_NS 10
`define FES_REPLY_MAX_NS  500
`define FES_REPLY_MAX_CYC ((`FES_REPLY_MAX_NS) / (`FES_CLK_PERIOD_NS))
`define FES_CMD_GAP_NS    15
`define FES_CMD_GAP_CYC   ((`FES_CMD_GAP_NS + `FES_CLK_PERIOD_NS - 1) / (`FES_CLK_PERIOD_NS))
`endif

/* File: fes_pkg.sv */
// Types of the front-end section command and data link logic
`include "fes_defs.svh"
package fes_pkg;
    typedef enum {FES_IDLE, FES_CODE, FES_ADDR, FES_WDATA} fes_rx_state_t;
    typedef struct packed {
        logic [`FES_CODE_W-1:0]  tag;
        logic [`FES_STAMP_W-1:0] stamp;
        logic [`FES_WDATA_W-1:0] data;
    } fes_entry_t;
endpackage : fes_pkg

/* File: fes_front_end_section.sv */
// Front-end section: control link command decoder, event buffers, data link sender
// How it works
// - Lines idle at zero; a command needs a zero then a one start bit.
// - Command and address fields are shifted in least significant bit first.
// - Run-time command is 5 code bits then 5 data bits, no address.
// - Setup command is 5 code bits, 5 address bits, then 16 data bits for write only.
// - Code 1E resets the section; 1F, no-op and unknown codes do nothing.
// - A new start bit right after one idle zero is accepted.
// - Sync clears the timing counter and the bit rate divider.
// - Clear readout empties the event buffer pointers and count.
// - Trigger accept stores event data, trigger tag and timing count.
// - Reply only to read event or read-back, starting within 500 ns when the data link is idle, else after the frame in progress.
// - Header with start bit leads; header and data are whole byte pairs.
// - Event data ends with zero trailer bytes; read-back ends in idle zeros.
// - Header, data and trailer go out without gaps, same format everywhere.
// - Data link bit rate is full, half or quarter rate.
// - Header bit one is start, bit two event type, then 5-bit tag.
`timescale 1ns/10ps
`include "fes_defs.svh"
module fes_front_end_section
    import fes_pkg::*;
(
    input  wire logic                      mclk,
    input  wire logic                      reset_n,
    input  wire logic                      control_link,
    input  wire logic [`FES_WDATA_W-1:0]   event_data,
    input  wire logic [7:0]                section_serial,
    input  wire logic [1:0]                rate_sel,
    output logic                           data_link,
    output logic                           subsystem_reset,
    output logic [`FES_CNT_W-1:0]          buffer_count,
    output logic [`FES_WDATA_W-1:0]        config_value
);
    localparam int REPLY_MAX = `FES_REPLY_MAX_CYC;

    logic                      ctl_s1;
    logic                      ctl_s2;
    logic                      prev_zero;
    fes_rx_state_t             state;
    logic [`FES_BITCNT_W-1:0]  bit_cnt;
    logic [`FES_CODE_W-1:0]    code;
    logic [`FES_CODE_W-1:0]    addr;
    logic [`FES_WDATA_W-1:0]   wdata;
    logic                      exec;
    logic                      do_reset;
    logic [`FES_STAMP_W-1:0]   stamp;
    logic [1:0]                div;
    logic [1:0]                div_last;
    fes_entry_t                evt_mem [`FES_DEPTH];
    logic [`FES_PTR_W-1:0]     wr_ptr;
    logic [`FES_PTR_W-1:0]     rd_ptr;
    logic                      pend_evt;
    logic                      pend_rb;
    logic                      busy;
    logic [`FES_FRAME_W-1:0]   shreg;
    logic [`FES_LEN_W-1:0]     bits_left;
    logic                      load_evt;
    logic                      load_rb;
    logic                      push;
    logic                      bit_end;

    assign do_reset = exec && code == `FES_SU_RESET;
    assign push     = exec && code == `FES_RT_L1A
                      && buffer_count != `FES_CNT_W'(`FES_DEPTH);
    assign load_evt = !busy && pend_evt && buffer_count != '0;
    assign load_rb  = !busy && !load_evt && pend_rb;
    assign bit_end  = div == div_last;

    // Pin input resynchronised before the decoder looks at it
    always_ff @(posedge mclk) begin
        ctl_s1 <= control_link;
        ctl_s2 <= ctl_s1;
    end

    // Command decoder; the last field completes on the same edge that raises exec
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state     <= FES_IDLE;
            bit_cnt   <= '0;
            code      <= '0;
            addr      <= '0;
            wdata     <= '0;
            exec      <= 1'b0;
            prev_zero <= 1'b0;
        end else begin
            exec <= 1'b0;
            case (state)
                FES_IDLE: begin
                    prev_zero <= !ctl_s2;
                    if (ctl_s2 && prev_zero) begin
                        state   <= FES_CODE;
                        bit_cnt <= '0;
                    end
                end
                FES_CODE: begin
                    code    <= {ctl_s2, code[`FES_CODE_W-1:1]};
                    bit_cnt <= bit_cnt + 1'b1;
                    if (bit_cnt == `FES_FIELD_LAST) begin
                        state   <= FES_ADDR;
                        bit_cnt <= '0;
                    end
                end
                FES_ADDR: begin
                    addr    <= {ctl_s2, addr[`FES_CODE_W-1:1]};
                    bit_cnt <= bit_cnt + 1'b1;
                    if (bit_cnt == `FES_FIELD_LAST) begin
                        bit_cnt <= '0;
                        if (code == `FES_SU_WRITE) begin
                            state <= FES_WDATA;
                        end else begin
                            state     <= FES_IDLE;
                            exec      <= 1'b1;
                            prev_zero <= 1'b0;
                        end
                    end
                end
                FES_WDATA: begin
                    wdata   <= {ctl_s2, wdata[`FES_WDATA_W-1:1]};
                    bit_cnt <= bit_cnt + 1'b1;
                    if (bit_cnt == `FES_WDATA_LAST) begin
                        state     <= FES_IDLE;
                        exec      <= 1'b1;
                        prev_zero <= 1'b0;
                    end
                end
                default: state <= FES_IDLE;
            endcase
        end
    end

    // Setup commands; 1F and undefined codes fall through as no-ops
    always_ff @(posedge mclk) begin
        if (!reset_n || do_reset) begin
            config_value <= '0;
        end else if (exec && code == `FES_SU_WRITE) begin
            config_value <= wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            subsystem_reset <= 1'b0;
        end else begin
            subsystem_reset <= do_reset;
        end
    end

    // Timing counter and bit rate divider, both cleared by sync
    always_comb begin
        case (rate_sel)
            `FES_RATE_FULL: div_last = `FES_DIV_FULL;
            `FES_RATE_HALF: div_last = `FES_DIV_HALF;
            default:        div_last = `FES_DIV_QUARTER;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n || do_reset || (exec && code == `FES_RT_SYNC)) begin
            stamp <= '0;
            div   <= '0;
        end else begin
            stamp <= stamp + 1'b1;
            div   <= (bit_end || !busy) ? 2'h0 : div + 1'b1;
        end
    end

    // Event buffers; push is refused while all four are full, so they never overrun
    always_ff @(posedge mclk) begin
        if (push) begin
            evt_mem[wr_ptr] <= '{tag: addr, stamp: stamp, data: event_data};
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n || do_reset || (exec && code == `FES_RT_CLEAR)) begin
            wr_ptr       <= '0;
            rd_ptr       <= '0;
            buffer_count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (load_evt) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            buffer_count <= buffer_count + {2'h0, push} - {2'h0, load_evt};
        end
    end

    // Pending replies; a new request in the load cycle is kept
    always_ff @(posedge mclk) begin
        if (!reset_n || do_reset) begin
            pend_evt <= 1'b0;
            pend_rb  <= 1'b0;
        end else begin
            if (exec && code == `FES_RT_READ) begin
                pend_evt <= 1'b1;
            end else if (load_evt || (!busy && buffer_count == '0)) begin
                pend_evt <= 1'b0;
            end
            if (exec && code == `FES_SU_READBACK) begin
                pend_rb <= 1'b1;
            end else if (load_rb) begin
                pend_rb <= 1'b0;
            end
        end
    end

    // Serialiser; frame goes out LSB first with no gap until empty
    always_ff @(posedge mclk) begin
        if (!reset_n || do_reset) begin
            busy      <= 1'b0;
            shreg     <= '0;
            bits_left <= '0;
            data_link <= 1'b0;
        end else begin
            data_link <= busy ? shreg[0] : 1'b0;
            if (load_evt) begin
                busy      <= 1'b1;
                bits_left <= `FES_EVT_LEN;
                shreg     <= {16'h0000, evt_mem[rd_ptr].data, 8'h00, section_serial,
                              3'h0, evt_mem[rd_ptr].stamp, 1'b0,
                              evt_mem[rd_ptr].tag, 1'b1, 1'b1};
            end else if (load_rb) begin
                busy      <= 1'b1;
                bits_left <= `FES_RB_LEN;
                shreg     <= {16'h0000, config_value, 8'h00, section_serial,
                              3'h0, addr, 1'b0, `FES_SU_READBACK, 1'b0, 1'b1};
            end else if (busy && bit_end) begin
                shreg     <= {1'b0, shreg[`FES_FRAME_W-1:1]};
                bits_left <= bits_left - 1'b1;
                if (bits_left == `FES_LEN_W'(1)) begin
                    busy <= 1'b0;
                end
            end
        end
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    idle_low_a: assert property (!busy |=> !data_link)
        else $error("data link not at zero while idle");
    start_bit_a: assert property ($rose(busy) |=> data_link)
        else $error("reply did not open with a start bit");
    need_zero_a: assert property (state == FES_IDLE && ctl_s2 && !prev_zero |=> state == FES_IDLE)
        else $error("command started without a leading zero");
    code_len_a: assert property (state == FES_CODE && bit_cnt == `FES_FIELD_LAST |=> state == FES_ADDR)
        else $error("command code field not five bits");
    reset_cmd_a: assert property (do_reset |=> subsystem_reset && config_value == '0 && !busy)
        else $error("subsystem reset command not obeyed");
    sync_clear_a: assert property (exec && code == `FES_RT_SYNC && !do_reset |=> stamp == '0 && div == '0)
        else $error("sync did not clear counters");
    clear_ptr_a: assert property (exec && code == `FES_RT_CLEAR |=> buffer_count == '0)
        else $error("clear readout left buffers occupied");
    store_evt_a: assert property (push && !load_evt |=> buffer_count == $past(buffer_count) + 1'b1)
        else $error("trigger accept did not fill a buffer");
    reply_time_a: assert property (exec && code == `FES_RT_READ && !busy && buffer_count != '0
                                   |-> ##[1:REPLY_MAX] busy)
        else $error("read event reply started too late");
    no_unasked_a: assert property ($rose(busy) |-> $past(pend_evt) || $past(pend_rb))
        else $error("reply sent without a request");
    gapless_a: assert property (busy && bits_left > `FES_LEN_W'(1) |=> busy)
        else $error("reply frame broken by a gap");

    evt_reply_c: cover property (exec && code == `FES_RT_READ ##[1:REPLY_MAX] $rose(busy));
    readback_c:  cover property (load_rb ##1 busy [*8]);
    write_c:     cover property (exec && code == `FES_SU_WRITE);
    full_c:      cover property (buffer_count == `FES_CNT_W'(`FES_DEPTH));
endmodule : fes_front_end_section

/* File: fes_link_partner.sv */
// Readout side model: control link command sender and data link frame receiver
`timescale 1ns/10ps
`include "fes_defs.svh"
module fes_link_partner
    import fes_pkg::*;
(
    input  wire logic mclk,
    input  wire logic data_link,
    output logic      control_link
);
    initial control_link = 1'h0;

    // Leading zero is the idle gap before the call, so back-to-back calls give one zero
    task automatic send_cmd(input logic [4:0] code, input logic [4:0] addr, input logic [15:0] wd);
        logic [26:0] bits;
        int          n;
        bits = {wd, addr, code, 1'h1};
        n = (code == `FES_SU_WRITE) ? 27 : 11;
        // Launch moves only in whole clock steps; finer delay is the section's job
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            control_link <= bits[i];
        end
        @(posedge mclk);
        control_link <= 1'h0;
    endtask : send_cmd

    // Raw bit string, LSB first, used to break the leading zero on purpose
    task automatic send_raw(input logic [22:0] bits);
        for (int i = 0; i < 23; i++) begin
            @(posedge mclk);
            control_link <= bits[i];
        end
        @(posedge mclk);
        control_link <= 1'h0;
    endtask : send_raw

    // Start found by its start bit, end by counting bits, then idle zeros watched
    task automatic get_frame(input int nbits, input int per, output logic [63:0] f,
                             output bit got, output bit quiet);
        f = 64'h0;
        got = 1'b0;
        quiet = 1'b1;
        for (int w = 0; w < `FES_REPLY_MAX_CYC && !got; w++) begin
            @(negedge mclk);
            got = (data_link === 1'h1);
        end
        if (got) begin
            f[0] = 1'h1;
            for (int i = 1; i < nbits; i++) begin
                repeat (per) @(negedge mclk);
                f[i] = data_link;
            end
            // Sampling sits at the head of each bit, so let the last bit run out first
            repeat (per - 1) @(negedge mclk);
            repeat (8 * per) begin
                @(negedge mclk);
                if (data_link !== 1'h0) quiet = 1'b0;
            end
        end
    endtask : get_frame
endmodule : fes_link_partner

/* File: tb_fes_front_end_section.sv */
// Self-checking bench of the front-end section
`timescale 1ns/10ps
`include "fes_defs.svh"
module tb_fes_front_end_section import fes_pkg::*;;
    localparam logic [63:0] msk_ev = ~64'h0000_0000_0000_1F00;
    logic        mclk = 1'h0;
    logic        reset_n = 1'h0;
    logic [15:0] event_data = 16'h0000;
    logic [7:0]  section_serial = 8'hA5;
    logic [1:0]  rate_sel = 2'h0;
    logic        control_link;
    logic        data_link;
    logic        subsystem_reset;
    logic [2:0]  buffer_count;
    logic [15:0] config_value;
    logic [63:0] fr;
    bit          got;
    bit          quiet;
    int          num_errors = 0;
    int          tests_run = 0;

    always #5 mclk = ~mclk;

    fes_front_end_section DUT (.mclk(mclk), .reset_n(reset_n), .control_link(control_link),
        .event_data(event_data), .section_serial(section_serial), .rate_sel(rate_sel),
        .data_link(data_link), .subsystem_reset(subsystem_reset),
        .buffer_count(buffer_count), .config_value(config_value));
    fes_link_partner link (.mclk(mclk), .data_link(data_link), .control_link(control_link));

    task automatic check_val(input string what, input logic [63:0] exp, input logic [63:0] seen);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check_val

    task automatic check_frame(input logic [63:0] exp, input logic [63:0] msk);
        check_val("reply present", 64'h1, {63'h0, got});
        check_val("reply frame", exp & msk, fr & msk);
        check_val("idle after reply", 64'h1, {63'h0, quiet});
    endtask : check_frame

    function automatic logic [63:0] ev_exp(input logic [4:0] tag, input logic [15:0] d);
        return {16'h0000, d, 8'h00, section_serial, 3'h0, 5'h00, 1'h0, tag, 1'h1, 1'h1};
    endfunction : ev_exp

    function automatic logic [63:0] rb_exp(input logic [4:0] addr, input logic [15:0] c);
        return {16'h0000, c, 8'h00, section_serial, 3'h0, addr, 1'h0, 5'h1B, 1'h0, 1'h1};
    endfunction : rb_exp

    task automatic gap(input int n);
        repeat (n) @(posedge mclk);
    endtask : gap

    task automatic no_reply();
        link.get_frame(64, 1, fr, got, quiet);
        check_val("unsolicited reply", 64'h0, {63'h0, got});
    endtask : no_reply

    task automatic trig(input logic [4:0] tag, input logic [15:0] d);
        @(posedge mclk);
        event_data <= d;
        link.send_cmd(`FES_RT_L1A, tag, 16'h0000);
    endtask : trig

    task automatic read_ev();
        link.send_cmd(`FES_RT_READ, 5'h00, 16'h0000);
        link.get_frame(64, 1, fr, got, quiet);
    endtask : read_ev

    task automatic t_idle();
        check_val("outputs after reset", 64'h0, {data_link, subsystem_reset, buffer_count, config_value});
        no_reply();
    endtask : t_idle

    task automatic t_events();
        for (int k = 0; k < 4; k++) begin
            trig(5'(k * 7 + 3), 16'hC0DE ^ 16'(k));
            no_reply();
            gap(170);
            check_val("buffer count", 64'(k + 1), 64'(buffer_count));
        end
        for (int k = 0; k < 4; k++) begin
            read_ev();
            check_frame(ev_exp(5'(k * 7 + 3), 16'hC0DE ^ 16'(k)), msk_ev);
            check_val("buffer count", 64'(3 - k), 64'(buffer_count));
        end
    endtask : t_events

    task automatic t_clear();
        trig(5'h15, 16'h1234);
        gap(230);
        trig(5'h0A, 16'h4321);
        read_ev();
        check_frame(ev_exp(5'h15, 16'h1234), msk_ev);
        check_val("buffer count", 64'h1, 64'(buffer_count));
        link.send_cmd(`FES_RT_CLEAR, 5'h00, 16'h0000);
        gap(8);
        check_val("buffer count", 64'h0, 64'(buffer_count));
        gap(230);
        link.send_cmd(`FES_RT_READ, 5'h00, 16'h0000);
        no_reply();
        link.send_raw(23'h001801);
        gap(20);
        check_val("buffer count", 64'h0, 64'(buffer_count));
    endtask : t_clear

    task automatic t_setup();
        link.send_cmd(`FES_SU_WRITE, 5'h09, 16'hC3A5);
        for (int r = 0; r < 3; r++) begin
            link.send_cmd(`FES_SU_READBACK, 5'h12, 16'h0000);
            link.get_frame(48, 1 << r, fr, got, quiet);
            check_frame(rb_exp(5'h12, 16'hC3A5), 64'h0000_FFFF_FFFF_FFFF);
            @(posedge mclk);
            rate_sel <= (r == 0) ? 2'h1 : ((r == 1) ? 2'h3 : 2'h0);
        end
        check_val("config value", 64'hC3A5, 64'(config_value));
    endtask : t_setup

    task automatic t_codes();
        logic [4:0] codes [5] = '{5'h1F, 5'h00, 5'h05, 5'h0A, 5'h1C};
        int         pulses;
        pulses = 0;
        trig(5'h07, 16'h0F0F);
        for (int i = 0; i < 5; i++) begin
            link.send_cmd(codes[i], 5'h03, 16'h0000);
            no_reply();
        end
        check_val("state after no-ops", {32'h0, 16'h0001, 16'hC3A5}, {buffer_count, config_value});
        link.send_cmd(`FES_SU_RESET, 5'h00, 16'h0000);
        repeat (10) begin
            @(negedge mclk);
            if (subsystem_reset === 1'h1) pulses++;
        end
        check_val("reset pulse cycles", 64'h1, 64'(pulses));
        check_val("state after reset", 64'h0, {buffer_count, config_value});
    endtask : t_codes

    // Same sync-to-trigger spacing twice must give the same stamp; a free counter drifts
    task automatic t_sync();
        logic [4:0] st [2];
        for (int i = 0; i < 2; i++) begin
            link.send_cmd(`FES_RT_SYNC, 5'h00, 16'h0000);
            trig(5'h11, 16'h5A5A);
            gap(230);
            read_ev();
            check_frame(ev_exp(5'h11, 16'h5A5A), msk_ev);
            st[i] = fr[12:8];
            gap(3);
        end
        check_val("stamp after sync", 64'(st[0]), 64'(st[1]));
        check_val("stamp value", 64'h0C, 64'(st[0]));
    endtask : t_sync

    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (16) @(posedge mclk);
        reset_n <= 1'h1;
        gap(4);
        t_idle();
        t_events();
        t_clear();
        t_setup();
        t_codes();
        t_sync();
        give_verdict();
    end

    initial begin
        repeat (30000) @(posedge mclk);
        num_errors++;
        give_verdict();
    end
endmodule : tb_fes_front_end_section
